/* logic/excitation_switch_matrix_regs.sv */
// Switch matrix control registers for the excitation amplifier
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "swmx_params.svh"
module excitation_switch_matrix_regs #(
  parameter int ADDR_W = 32
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire swmx_pkg::reg_req_t bus_req,
  output logic             [31:0] rd_data,
  output swmx_pkg::neg_switches_t neg_sw,
  output swmx_pkg::pos_switches_t pos_sw
);
  import swmx_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Decode compares a full 32-bit address
  if (ADDR_W != 32) begin : g_bad_addr
    $error("ADDR_W must be 32");
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] addr,
                                    input logic [31:0] target);
    addr_hit = (addr == target);
  endfunction

  logic        sel_neg;
  logic        sel_pos;
  logic        wr_neg;
  logic        wr_pos;
  logic [31:0] neg_value;
  logic [31:0] pos_value;

  always_comb begin
    sel_neg = 1'b0;
    sel_pos = 1'b0;
    if (addr_hit(bus_req.addr, `SWMX_NEG_ADDR)) begin
      sel_neg = 1'b1;
    end else if (addr_hit(bus_req.addr, `SWMX_POS_ADDR)) begin
      sel_pos = 1'b1;
    end
  end

  assign wr_neg = bus_req.wr && sel_neg;
  assign wr_pos = bus_req.wr && sel_pos;

  // ----------------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------------
  // Mask drops bit 7 and bits 31:12 on write
  switch_ctrl_reg #(
    .WMASK (`SWMX_NEG_WMASK),
    .RESET (`SWMX_NEG_RESET)
  ) u_neg_reg (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (wr_neg),
    .wdata    (bus_req.wdata),
    .value    (neg_value)
  );

  // Bits 14:0 all store; 31:15 never do
  switch_ctrl_reg #(
    .WMASK (`SWMX_POS_WMASK),
    .RESET (`SWMX_POS_RESET)
  ) u_pos_reg (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_en    (wr_pos),
    .wdata    (bus_req.wdata),
    .value    (pos_value)
  );

  reg_read_port u_read (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .rd_en     (bus_req.rd),
    .sel_neg   (sel_neg),
    .sel_pos   (sel_pos),
    .neg_value (neg_value),
    .pos_value (pos_value),
    .rd_data   (rd_data)
  );

  // ----------------------------------------------------------------------
  // Switch outputs
  // ----------------------------------------------------------------------
  // Pure wiring from flops, so no decode glitch reaches an analog switch
  assign neg_sw.neg_to_cal_resistor_b_sw = neg_value[`SWMX_N_CAL_B];
  assign neg_sw.neg_to_sense_direct_sw   =
    neg_value[`SWMX_N_SENSE_DIRECT];
  assign neg_sw.neg_to_aux3_via_load_sw  =
    neg_value[`SWMX_N_AUX3_LOAD];
  assign neg_sw.neg_to_sense_plain_sw    =
    neg_value[`SWMX_N_SENSE_PLAIN];
  assign neg_sw.neg_to_sense_via_load_sw =
    neg_value[`SWMX_N_SENSE_LOAD];
  assign neg_sw.neg_to_input3_sw         = neg_value[`SWMX_N_INPUT3];
  assign neg_sw.neg_to_input2_sw         = neg_value[`SWMX_N_INPUT2];
  assign neg_sw.neg_to_input1_sw         = neg_value[`SWMX_N_INPUT1];
  assign neg_sw.neg_to_input0_sw         = neg_value[`SWMX_N_INPUT0];
  assign neg_sw.neg_short_tia_sw         =
    neg_value[`SWMX_N_SHORT_TIA];
  assign neg_sw.neg_short_b_sw           = neg_value[`SWMX_N_SHORT_B];
  assign pos_sw.pos_short_b_sw           = pos_value[`SWMX_P_SHORT_B];
  assign pos_sw.pos_low_sw               =
    pos_value[`SWMX_P_LOW_MSB:0];

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_cal_b_write: assert property (
    wr_neg |=> neg_sw.neg_to_cal_resistor_b_sw ==
               $past(bus_req.wdata[`SWMX_N_CAL_B]))
    else $error("Calibration b switch does not follow write");

  a_sense_direct_hold: assert property (
    (!wr_neg && !sys_rst) |=> $stable(neg_sw.neg_to_sense_direct_sw))
    else $error("Direct sense switch moved without a write");

  a_aux3_write: assert property (
    (wr_neg && bus_req.wdata[`SWMX_N_AUX3_LOAD]) |=>
      neg_sw.neg_to_aux3_via_load_sw)
    else $error("Aux 3 switch not closed by write");

  a_sense_plain_open: assert property (
    (wr_neg && !bus_req.wdata[`SWMX_N_SENSE_PLAIN]) |=>
      !neg_sw.neg_to_sense_plain_sw)
    else $error("Plain sense switch not opened by write");

  a_sense_load_write: assert property (
    wr_neg ##1 !wr_neg |=>
      neg_sw.neg_to_sense_via_load_sw ==
      $past(bus_req.wdata[`SWMX_N_SENSE_LOAD], 2))
    else $error("Loaded sense switch lost its written value");

  a_inputs_write: assert property (
    wr_neg |=> {neg_sw.neg_to_input3_sw, neg_sw.neg_to_input2_sw,
                neg_sw.neg_to_input1_sw, neg_sw.neg_to_input0_sw} ==
               $past(bus_req.wdata[3:0]))
    else $error("Input switches do not follow write");

  a_pos_short_write: assert property (
    wr_pos |=> pos_sw.pos_short_b_sw ==
               $past(bus_req.wdata[`SWMX_P_SHORT_B]))
    else $error("Positive short b switch does not follow write");

  a_pos_independent: assert property (
    wr_neg |=> $stable(pos_sw))
    else $error("Positive switches moved on a negative write");

  a_neg_readback: assert property (
    (bus_req.rd && sel_neg) |=>
      rd_data == {20'h0_0000, $past(neg_value[11:8]), 1'b0,
                  $past(neg_value[6:0])})
    else $error("Negative readback wrong or reserved bits set");

  a_pos_reserved: assert property (
    (bus_req.rd && sel_pos) |=> rd_data[31:15] == 17'h0_0000)
    else $error("Positive reserved bits read nonzero");

  a_short_write: assert property (
    wr_neg |=> {neg_sw.neg_short_b_sw, neg_sw.neg_short_tia_sw} ==
               $past(bus_req.wdata[11:10]))
    else $error("Short switches do not follow write");

  a_unmapped_zero: assert property (
    (bus_req.rd && !sel_neg && !sel_pos) |=> rd_data == 32'h0000_0000)
    else $error("Unmapped read returned nonzero");

  // ----------------------------------------------------------------------
  // Write, hold, isolation, readback, storage and reset checks
  // ----------------------------------------------------------------------
  // Holds skip the edge that samples reset, where a clear is legal
  a_cal_b_hold: assert property (
    (!wr_neg && !sys_rst) |=> $stable(neg_sw.neg_to_cal_resistor_b_sw))
    else $error("Calibration b switch moved without a write");

  a_sense_direct_write: assert property (
    wr_neg |=> neg_sw.neg_to_sense_direct_sw ==
               $past(bus_req.wdata[`SWMX_N_SENSE_DIRECT]))
    else $error("Direct sense switch does not follow write");

  a_aux3_open: assert property (
    (wr_neg && !bus_req.wdata[`SWMX_N_AUX3_LOAD]) |=>
      !neg_sw.neg_to_aux3_via_load_sw)
    else $error("Aux 3 switch not opened by write");

  a_aux3_hold: assert property (
    (!wr_neg && !sys_rst) |=> $stable(neg_sw.neg_to_aux3_via_load_sw))
    else $error("Aux 3 switch moved without a write");

  a_sense_plain_close: assert property (
    (wr_neg && bus_req.wdata[`SWMX_N_SENSE_PLAIN]) |=>
      neg_sw.neg_to_sense_plain_sw)
    else $error("Plain sense switch not closed by write");

  a_sense_plain_hold: assert property (
    (!wr_neg && !sys_rst) |=> $stable(neg_sw.neg_to_sense_plain_sw))
    else $error("Plain sense switch moved without a write");

  a_sense_load_follow: assert property (
    wr_neg |=> neg_sw.neg_to_sense_via_load_sw ==
               $past(bus_req.wdata[`SWMX_N_SENSE_LOAD]))
    else $error("Loaded sense switch does not follow write");

  a_inputs_hold: assert property (
    (!wr_neg && !sys_rst) |=>
      $stable({neg_sw.neg_to_input3_sw, neg_sw.neg_to_input2_sw,
               neg_sw.neg_to_input1_sw, neg_sw.neg_to_input0_sw}))
    else $error("Input switches moved without a write");

  a_neg_full_write: assert property (
    wr_neg |=> neg_sw == {$past(bus_req.wdata[11:8]),
                          $past(bus_req.wdata[6:0])})
    else $error("Negative switches do not match the written word");

  a_pos_short_hold: assert property (
    (!wr_pos && !sys_rst) |=> $stable(pos_sw.pos_short_b_sw))
    else $error("Positive short b switch moved without a write");

  a_pos_full_write: assert property (
    wr_pos |=> pos_sw == $past(bus_req.wdata[14:0]))
    else $error("Positive switches do not match the written word");

  a_pos_low_write: assert property (
    wr_pos |=> pos_sw.pos_low_sw == $past(bus_req.wdata[13:0]))
    else $error("Positive low switches do not follow write");

  a_pos_low_hold: assert property (
    (!wr_pos && !sys_rst) |=> $stable(pos_sw.pos_low_sw))
    else $error("Positive low switches moved without a write");

  a_neg_independent: assert property (
    wr_pos |=> $stable(neg_sw))
    else $error("Negative switches moved on a positive write");

  a_short_hold: assert property (
    (!wr_neg && !sys_rst) |=>
      $stable({neg_sw.neg_short_b_sw, neg_sw.neg_short_tia_sw}))
    else $error("Short switches moved without a write");

  a_pos_readback: assert property (
    (bus_req.rd && sel_pos) |=>
      rd_data == {17'h0_0000, $past(pos_value[14:0])})
    else $error("Positive readback wrong");

  a_idle_read_zero: assert property (
    !bus_req.rd |=> rd_data == 32'h0000_0000)
    else $error("Read data stands outside its read cycle");

  a_read_no_store: assert property (
    (bus_req.rd && !sys_rst) |=> $stable(neg_sw) && $stable(pos_sw))
    else $error("A read moved a switch");

  // Near-miss addresses must not alias onto either register
  a_unmapped_write: assert property (
    (bus_req.wr && !sel_neg && !sel_pos && !sys_rst) |=>
      $stable(neg_sw) && $stable(pos_sw))
    else $error("A write to an unmapped address moved a switch");

  a_neg_reserved_store: assert property (
    (neg_value[31:12] == 20'h0_0000) && !neg_value[`SWMX_N_RESERVED7])
    else $error("Negative reserved bit holds a one");

  a_pos_reserved_store: assert property (
    pos_value[31:15] == 17'h0_0000)
    else $error("Positive reserved bit holds a one");

  // Storage checked apart from the outputs, so a wiring slip stands out
  a_reset_store: assert property (
    disable iff (1'b0)
    sys_rst |=> (neg_value == `SWMX_NEG_RESET) &&
                (pos_value == `SWMX_POS_RESET))
    else $error("Register storage not cleared by reset");

  a_reset_clear: assert property (
    disable iff (1'b0)
    sys_rst |=> (neg_sw == '0) && (pos_sw == '0) &&
                (rd_data == 32'h0000_0000))
    else $error("Outputs not cleared by reset");

endmodule

/* logic/swmx_params.svh */
// Offsets, bit positions, masks and reset values of the switch registers
`ifndef SWMX_PARAMS_SVH
`define SWMX_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SWMX_NEG_ADDR        32'h0000_2154
`define SWMX_POS_ADDR        32'h0000_2158

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define SWMX_NEG_RESET       32'h0000_0000
`define SWMX_POS_RESET       32'h0000_0000
`define SWMX_NEG_WMASK       32'h0000_0f7f
`define SWMX_POS_WMASK       32'h0000_7fff

// ----------------------------------------------------------------------
// Negative register bit positions
// ----------------------------------------------------------------------
`define SWMX_N_INPUT0        0
`define SWMX_N_INPUT1        1
`define SWMX_N_INPUT2        2
`define SWMX_N_INPUT3        3
`define SWMX_N_SENSE_LOAD    4
`define SWMX_N_SENSE_PLAIN   5
`define SWMX_N_AUX3_LOAD     6
`define SWMX_N_RESERVED7     7
`define SWMX_N_SENSE_DIRECT  8
`define SWMX_N_CAL_B         9
`define SWMX_N_SHORT_TIA     10
`define SWMX_N_SHORT_B       11

// ----------------------------------------------------------------------
// Positive register bit positions
// ----------------------------------------------------------------------
`define SWMX_P_SHORT_B       14
`define SWMX_P_LOW_MSB       13

`endif

/* logic/swmx_pkg.sv */
// Types shared by the switch matrix register bank
package swmx_pkg;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic neg_short_b_sw;
    logic neg_short_tia_sw;
    logic neg_to_cal_resistor_b_sw;
    logic neg_to_sense_direct_sw;
    logic neg_to_aux3_via_load_sw;
    logic neg_to_sense_plain_sw;
    logic neg_to_sense_via_load_sw;
    logic neg_to_input3_sw;
    logic neg_to_input2_sw;
    logic neg_to_input1_sw;
    logic neg_to_input0_sw;
  } neg_switches_t;

  typedef struct packed {
    logic        pos_short_b_sw;
    logic [13:0] pos_low_sw;
  } pos_switches_t;

endpackage

/* logic/switch_ctrl_reg.sv */
// One switch control register with a writable-bit mask
`timescale 1ns/1ps
module switch_ctrl_reg #(
  parameter logic [31:0] WMASK = 32'hffff_ffff,
  parameter logic [31:0] RESET = 32'h0000_0000
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wr_en,
  input  wire logic [31:0] wdata,
  output logic      [31:0] value
);

  logic [31:0] next_value;

  // ----------------------------------------------------------------------
  // Masked update
  // ----------------------------------------------------------------------
  // Reserved bits never store, so they cannot reach a switch
  always_comb begin
    next_value = value;
    if (wr_en) begin
      next_value = wdata & WMASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      value <= RESET;
    end else begin
      value <= next_value;
    end
  end

endmodule

/* logic/reg_read_port.sv */
// Registered read-back multiplexer for the switch registers
`timescale 1ns/1ps
module reg_read_port (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        rd_en,
  input  wire logic        sel_neg,
  input  wire logic        sel_pos,
  input  wire logic [31:0] neg_value,
  input  wire logic [31:0] pos_value,
  output logic      [31:0] rd_data
);

  logic [31:0] next_rd_data;

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  // Data stands one cycle only; unmapped addresses answer zero
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (rd_en && sel_neg) begin
      next_rd_data = neg_value;
    end else if (rd_en && sel_pos) begin
      next_rd_data = pos_value;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_data <= 32'h0000_0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule

/* dv/excitation_switch_matrix_regs_tb_top.sv */
// Self-checking bench for the switch matrix register bank
`timescale 1ns/1ps
module excitation_switch_matrix_regs_tb_top;
  import swmx_pkg::*;

  // ------------------------------------------------------------------
  // Addresses and table rows
  // ------------------------------------------------------------------
  localparam logic [31:0] NEG_A = 32'h0000_2154;
  localparam logic [31:0] POS_A = 32'h0000_2158;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdexp;
  } row_t;

  logic          core_clk;
  logic          sys_rst;
  reg_req_t      bus_req;
  logic [31:0]   rd_data;
  neg_switches_t neg_sw;
  pos_switches_t pos_sw;
  int            n_errors;
  int            checked;
  logic [31:0]   exp_neg;
  logic [31:0]   exp_pos;
  logic [31:0]   got;

  // Unmapped rows hit the neighbour slots and an unaligned byte; they must leave both alone
  row_t rows [10] = '{
    '{NEG_A, 32'hffff_ffff, 32'h0000_0f7f},
    '{NEG_A, 32'h0000_0080, 32'h0000_0000},
    '{NEG_A, 32'h0000_02aa, 32'h0000_022a},
    '{NEG_A, 32'h0000_0d55, 32'h0000_0d55},
    '{POS_A, 32'hffff_ffff, 32'h0000_7fff},
    '{POS_A, 32'h0001_4000, 32'h0000_4000},
    '{POS_A, 32'h0000_2aaa, 32'h0000_2aaa},
    '{32'h0000_215c, 32'hffff_ffff, 32'h0000_0000},
    '{32'h0000_2150, 32'h0000_0000, 32'h0000_0000},
    '{32'h0000_2155, 32'h0000_0000, 32'h0000_0000}
  };

  excitation_switch_matrix_regs u_excitation_switch_matrix_regs (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .bus_req  (bus_req),
    .rd_data  (rd_data),
    .neg_sw   (neg_sw),
    .pos_sw   (pos_sw)
  );

  always #5 core_clk = ~core_clk;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Expected switch vector: bit 7 has no switch behind it
  function automatic logic [31:0] nmap(input logic [31:0] v);
    return {21'h0, v[11:8], v[6:0]};
  endfunction

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr  <= a;
    bus_req.wdata <= d;
    bus_req.wr    <= 1'b1;
    @(posedge core_clk);
    bus_req.wr    <= 1'b0;
  endtask

  // Data is only valid in the single cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge core_clk);
    bus_req.addr <= a;
    bus_req.rd   <= 1'b1;
    @(posedge core_clk);
    bus_req.rd   <= 1'b0;
    #1;
    d = rd_data;
  endtask

  task automatic chk_sw();
    logic [31:0] e;
    e = nmap(exp_neg);
    chk("neg_sw_hi", {28'h0, neg_sw[10:7]}, {28'h0, e[10:7]});
    chk("neg_sw_mid", {29'h0, neg_sw[6:4]}, {29'h0, e[6:4]});
    chk("neg_sw_lo", {28'h0, neg_sw[3:0]}, {28'h0, e[3:0]});
    chk("pos_sw", {17'h0, pos_sw}, exp_pos);
  endtask

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    sys_rst  = 1'b1;
    bus_req  = '0;
    n_errors = 0;
    checked  = 0;
    exp_neg  = 32'h0;
    exp_pos  = 32'h0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1;
    chk_sw();
    rd(NEG_A, got);
    chk("neg_reset", got, 32'h0);
    rd(POS_A, got);
    chk("pos_reset", got, 32'h0);
    $display("Done: reset values");

    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wdata);
      if (rows[i].addr == NEG_A) exp_neg = rows[i].rdexp;
      if (rows[i].addr == POS_A) exp_pos = rows[i].rdexp;
      rd(rows[i].addr, got);
      chk("rd_table", got, rows[i].rdexp);
      chk_sw();
    end
    $display("Done: table");

    // Walking one over bits 0 to 16: each must reach exactly its own switch, or none where it has none
    for (int i = 0; i < 17; i++) begin
      wr(NEG_A, 32'h1 << i);
      wr(POS_A, 32'h1 << i);
      exp_neg = (i == 7 || i > 11) ? 32'h0 : 32'h1 << i;
      exp_pos = (i > 14) ? 32'h0 : 32'h1 << i;
      rd(NEG_A, got);
      chk("rd_neg_walk", got, exp_neg);
      rd(POS_A, got);
      chk("rd_pos_walk", got, exp_pos);
      chk_sw();
    end
    $display("Done: walking bit");

    // Write then read with no idle cycle between the strobes
    @(posedge core_clk);
    bus_req.addr  <= NEG_A;
    bus_req.wdata <= 32'h0000_0311;
    bus_req.wr    <= 1'b1;
    @(posedge core_clk);
    bus_req.wr    <= 1'b0;
    bus_req.rd    <= 1'b1;
    @(posedge core_clk);
    bus_req.rd    <= 1'b0;
    exp_neg = 32'h0000_0311;
    #1;
    chk("rd_b2b", rd_data, 32'h0000_0311);
    chk_sw();
    @(posedge core_clk);
    #1;
    chk("rd_idle", rd_data, 32'h0);
    $display("Done: back to back");

    // Reset in mid-run must open every switch again
    wr(POS_A, 32'h0000_4001);
    exp_pos = 32'h0000_4001;
    @(posedge core_clk);
    sys_rst <= 1'b1;
    #1;
    chk_sw();
    @(posedge core_clk);
    sys_rst <= 1'b0;
    exp_neg = 32'h0;
    exp_pos = 32'h0;
    #1;
    chk_sw();
    rd(POS_A, got);
    chk("pos_rerst", got, 32'h0);
    $display("Done: mid-run reset");
    report_and_stop();
  end
endmodule
